// File: rtl/can_rtb_pkg.sv
package can_rtb_pkg;
	localparam int NBUF = 16;
	localparam int IDX_W = 4;
	localparam int ID_W = 29;
	localparam int TS_W = 16;
	localparam int DW = 16;
	// buffer codes; only the response code is fixed by the protocol layer
	localparam logic [3:0] CODE_RESPOND = 4'hA;
	localparam logic [3:0] CODE_RX_EMPTY = 4'h4;
	localparam logic [3:0] CODE_RX_FULL = 4'h2;
	localparam logic [3:0] CODE_TX_IDLE = 4'h8;
	localparam logic [7:0] A_CTRL_A = 8'h00;
	localparam logic [7:0] A_CTRL_B = 8'h01;
	localparam logic [7:0] A_DIV = 8'h02;
	localparam logic [7:0] A_MODE = 8'h03;
	localparam logic [7:0] A_TIMER = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h05;
	localparam logic [1:0] WIN_SEL = 2'h2;
	localparam logic [1:0] W_CTRL = 2'h0;
	localparam logic [1:0] W_IDH = 2'h1;
	localparam logic [1:0] W_IDL = 2'h2;
	localparam int SEG_W = 3;
	localparam int PS2_LSB = 0;
	localparam int PROP_LSB = 0;
	localparam int PS1_LSB = 3;
	localparam int RJW_LSB = 6;
	localparam int RJW_W = 2;
	localparam int MODE_LISTEN = 0;
	localparam int MODE_TSYNC = 1;
	localparam logic [7:0] RST_CTRL_A = 8'h03;
	localparam logic [7:0] RST_CTRL_B = 8'h5B;
	localparam logic [7:0] RST_DIV = 8'h04;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [4:0] IPT_ONE_CLK = 5'h03;
	localparam logic [4:0] IPT_MULTI = 5'h02;
	localparam logic [2:0] PS2_LATE = 3'h2;
	localparam logic [13:0] MIN_BIT_CLKS = 14'h000A;

	typedef struct packed {
		logic [3:0] code;
		logic rtr;
		logic ide;
		logic [ID_W-1:0] id;
		logic [TS_W-1:0] ts;
	} buf_entry_s;

	typedef struct packed {
		logic busy;
		logic id_start;
		logic intermission;
		logic eof;
		logic rx_role;
		logic delim;
		logic [3:0] bit_idx;
	} frame_pos_s;

	typedef struct packed {
		logic stb;
		logic rtr;
		logic ide;
		logic [IDX_W-1:0] idx;
		logic [ID_W-1:0] id;
	} ev_s;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] idx;
		logic remote;
	} tx_req_s;

	typedef struct packed {
		logic win;
		logic rd;
		logic we;
		logic [IDX_W-1:0] idx;
		logic [1:0] word;
		logic [DW-1:0] wdata;
		logic [DW-1:0] alt;
	} hport_s;

	typedef struct packed {
		logic we;
		logic [IDX_W-1:0] idx;
		buf_entry_s mask;
		buf_entry_s wdata;
	} eport_s;

	typedef enum logic [2:0] {
		E_IDLE = 3'b000,
		E_SCAN_RD = 3'b001,
		E_SCAN_CMP = 3'b010,
		E_TXD_RD = 3'b011,
		E_TXD_WR = 3'b100
	} eng_e;
endpackage : can_rtb_pkg

// File: rtl/buf_mem.sv
module buf_mem #(
	parameter int DEPTH = can_rtb_pkg::NBUF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input can_rtb_pkg::hport_s h,
	output logic [can_rtb_pkg::DW-1:0] h_rdata,
	input can_rtb_pkg::eport_s e,
	output can_rtb_pkg::buf_entry_s e_rdata
);
	import can_rtb_pkg::*;

	typedef struct packed {
		buf_entry_s [DEPTH-1:0] ent;
		buf_entry_s erd;
		logic [DW-1:0] hrd;
	} mem_s;

	mem_s r;
	mem_s n;

	always_comb begin
		buf_entry_s cur;
		logic [DW-1:0] w;
		cur = r.ent[h.idx];
		w = '0;
		n = r;
		case (h.word)
			W_CTRL: w = {10'h000, cur.ide, cur.rtr, cur.code};
			W_IDH: w = {3'h0, cur.id[28:16]};
			W_IDL: w = cur.id[15:0];
			default: w = cur.ts;
		endcase
		n.hrd = '0;
		if (h.rd) begin
			n.hrd = h.win ? w : h.alt;
		end
		if (h.we && h.win) begin
			case (h.word)
				W_CTRL: begin
					n.ent[h.idx].code = h.wdata[3:0];
					n.ent[h.idx].rtr = h.wdata[4];
					n.ent[h.idx].ide = h.wdata[5];
				end
				W_IDH: n.ent[h.idx].id[28:16] = h.wdata[12:0];
				W_IDL: n.ent[h.idx].id[15:0] = h.wdata;
				default: n.ent[h.idx].ts = h.wdata;
			endcase
		end
		n.erd = r.ent[e.idx];
		// engine write lands on top of a host write: engine wins overlap
		if (e.we) begin
			n.ent[e.idx] = (n.ent[e.idx] & ~e.mask) | (e.wdata & e.mask);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign h_rdata = r.hrd;
	assign e_rdata = r.erd;
endmodule : buf_mem

// File: rtl/can_remote_timestamp_bittiming.sv
// The plain strobed port and the address map were left to the implementer.
module can_remote_timestamp_bittiming (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [can_rtb_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [can_rtb_pkg::DW-1:0] reg_rdata,
	input wire logic can_rx,
	output logic can_tx,
	input can_rtb_pkg::frame_pos_s pos,
	input wire logic tx_bit,
	input wire logic ack_req,
	input can_rtb_pkg::ev_s rx_frame,
	input can_rtb_pkg::ev_s movein,
	input can_rtb_pkg::ev_s tx_done,
	input wire logic tx_grant,
	output logic sample_pulse,
	output logic sampled_bit,
	output logic overload_start,
	output can_rtb_pkg::ev_s store_req,
	output can_rtb_pkg::tx_req_s tx_req,
	output logic freeze_counters,
	output logic error_passive
);
	import can_rtb_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] div;
		logic [7:0] mode;
		logic rx_m;
		logic rx_s;
		logic rx_prev;
		logic [7:0] pre_cnt;
		logic [4:0] tq_cnt;
		logic sample_pt;
		logic sampled;
		logic ovl_pend;
		logic overload;
		logic can_tx;
		logic [TS_W-1:0] timer;
		logic [TS_W-1:0] cap;
		ev_s store;
		ev_s p_rmt;
		ev_s p_mov;
		ev_s p_txd;
		tx_req_s txq;
		eng_e st;
		logic [IDX_W-1:0] scan;
		logic freeze;
	} st_s;

	st_s r;
	st_s n;
	hport_s hp;
	eport_s ep;
	buf_entry_s erd;
	logic tick;
	logic hard;
	logic restart;
	logic hit;
	logic [4:0] samp;
	logic [4:0] last;
	logic [4:0] procpt;
	logic [13:0] cpb;

	always_comb begin
		logic [2:0] prop;
		logic [2:0] ps1;
		logic [2:0] ps2;
		logic [4:0] sjw;
		logic [4:0] info_processing_time;
		logic [4:0] rem;
		logic edge_n;
		logic txpt;
		logic proc;
		logic listen;
		logic clr_mov;
		logic clr_txd;
		logic clr_rmt;
		logic win;
		prop = r.ctrl_b[PROP_LSB +: SEG_W];
		ps1 = r.ctrl_b[PS1_LSB +: SEG_W];
		ps2 = r.ctrl_a[PS2_LSB +: SEG_W];
		sjw = 5'(r.ctrl_b[RJW_LSB +: RJW_W]) + 5'h01;
		n = r;
		clr_mov = 1'b0;
		clr_txd = 1'b0;
		clr_rmt = 1'b0;
		listen = r.mode[MODE_LISTEN];
		win = (reg_addr[7:6] == WIN_SEL);
		n.rx_m = can_rx;
		n.rx_s = r.rx_m;
		n.rx_prev = r.rx_s;
		samp = 5'(prop) + 5'(ps1) + 5'h02;
		last = samp + 5'(ps2) + 5'h01;
		info_processing_time = (r.div == 8'h00) ? IPT_ONE_CLK : IPT_MULTI;
		procpt = (samp + info_processing_time > last) ? last : samp + info_processing_time;
		cpb = 14'((14'(r.div) + 14'h0001) * (14'(last) + 14'h0001));
		tick = (r.pre_cnt == r.div);
		n.pre_cnt = tick ? 8'h00 : r.pre_cnt + 8'h01;
		if (tick) begin
			n.tq_cnt = (r.tq_cnt == last) ? 5'h00 : r.tq_cnt + 5'h01;
		end
		edge_n = r.rx_prev & ~r.rx_s;
		hard = edge_n & ~pos.busy;
		restart = hard;
		rem = last - r.tq_cnt + 5'h01;
		if (hard) begin
			n.tq_cnt = 5'h00;
			n.pre_cnt = 8'h00;
		end else if (edge_n && r.tq_cnt != 5'h00) begin
			// late edge stretches phase one, early edge trims phase two
			if (r.tq_cnt <= samp) begin
				n.tq_cnt = (r.tq_cnt > sjw) ? r.tq_cnt - sjw : 5'h00;
			end else if (rem <= sjw) begin
				restart = 1'b1;
				n.tq_cnt = 5'h00;
				n.pre_cnt = 8'h00;
			end else begin
				n.tq_cnt = r.tq_cnt + sjw;
			end
		end
		n.sample_pt = tick && r.tq_cnt == samp && !edge_n;
		if (n.sample_pt) begin
			n.sampled = r.rx_s;
			n.timer = r.timer + 16'h0001;
			if (!r.rx_s) begin
				if (pos.intermission && pos.bit_idx < 4'h2) begin
					n.ovl_pend = 1'b1;
				end
				if (pos.eof && pos.rx_role && pos.bit_idx == 4'h6) begin
					n.ovl_pend = 1'b1;
				end
				if (pos.delim && pos.bit_idx == 4'h7) begin
					n.ovl_pend = 1'b1;
				end
			end
		end
		if (movein.stb && movein.idx == '0 && r.mode[MODE_TSYNC]) begin
			n.timer = '0;
		end
		if (pos.id_start) begin
			n.cap = r.timer;
		end
		// overload decision is only ready after the processing time
		proc = tick && r.tq_cnt == procpt;
		n.overload = 1'b0;
		if (proc) begin
			n.overload = r.ovl_pend;
			n.ovl_pend = 1'b0;
		end
		// transmit point; late by one quantum when phase two is set to PS2_LATE
		txpt = tick && ((ps2 == PS2_LATE) ? r.tq_cnt == 5'h00 :
			r.tq_cnt == last);
		if (listen) begin
			n.can_tx = 1'b1;
		end else if (txpt) begin
			n.can_tx = tx_bit & ~(ack_req & ~listen);
		end
		n.freeze = listen;
		n.store = '0;
		if (rx_frame.stb && !rx_frame.rtr) begin
			n.store = rx_frame;
		end
		if (tx_grant) begin
			n.txq.valid = 1'b0;
		end
		ep = '0;
		ep.idx = r.scan;
		hit = erd.code == CODE_RESPOND && erd.ide == r.p_rmt.ide &&
			erd.id == r.p_rmt.id;
		case (r.st)
			E_IDLE: begin
				if (r.p_mov.stb) begin
					ep.we = 1'b1;
					ep.idx = r.p_mov.idx;
					ep.mask.code = '1;
					ep.mask.ide = 1'b1;
					ep.mask.id = '1;
					ep.mask.ts = '1;
					ep.wdata.code = CODE_RX_FULL;
					ep.wdata.ide = r.p_mov.ide;
					ep.wdata.id = r.p_mov.id;
					ep.wdata.ts = r.cap;
					clr_mov = 1'b1;
				end else if (r.p_txd.stb) begin
					n.st = E_TXD_RD;
				end else if (r.p_rmt.stb) begin
					n.scan = '0;
					n.st = E_SCAN_RD;
				end
			end
			E_TXD_RD: begin
				ep.idx = r.p_txd.idx;
				n.st = E_TXD_WR;
			end
			E_TXD_WR: begin
				ep.we = 1'b1;
				ep.idx = r.p_txd.idx;
				ep.mask.ts = '1;
				ep.wdata.ts = r.cap;
				// response buffers stay armed for the next request
				if (erd.code != CODE_RESPOND) begin
					ep.mask.code = '1;
					ep.wdata.code = erd.rtr ? CODE_RX_EMPTY :
						CODE_TX_IDLE;
				end
				clr_txd = 1'b1;
				n.st = E_IDLE;
			end
			E_SCAN_RD: begin
				n.st = E_SCAN_CMP;
			end
			E_SCAN_CMP: begin
				if (hit) begin
					// wait for a free slot so no request is dropped
					if (!r.txq.valid) begin
						n.txq.valid = 1'b1;
						n.txq.idx = r.scan;
						n.txq.remote = erd.rtr;
						clr_rmt = 1'b1;
						n.st = E_IDLE;
					end
				end else if (r.scan == IDX_W'(NBUF - 1)) begin
					clr_rmt = 1'b1;
					n.st = E_IDLE;
				end else begin
					n.scan = r.scan + 1'b1;
					n.st = E_SCAN_RD;
				end
			end
			default: n.st = E_IDLE;
		endcase
		// new event in the clearing cycle wins over the clear
		if (clr_mov) n.p_mov = '0;
		if (clr_txd) n.p_txd = '0;
		if (clr_rmt) n.p_rmt = '0;
		if (movein.stb) n.p_mov = movein;
		if (tx_done.stb) n.p_txd = tx_done;
		if (rx_frame.stb && rx_frame.rtr) n.p_rmt = rx_frame;
		if (reg_wr) begin
			case (reg_addr)
				A_CTRL_A: n.ctrl_a = reg_wdata[7:0];
				A_CTRL_B: n.ctrl_b = reg_wdata[7:0];
				A_DIV: n.div = reg_wdata[7:0];
				A_MODE: n.mode = {6'h00, reg_wdata[1:0]};
				default: ;
			endcase
		end
		hp = '0;
		hp.win = win;
		hp.rd = reg_rd;
		hp.we = reg_wr;
		hp.idx = reg_addr[5:2];
		hp.word = reg_addr[1:0];
		hp.wdata = reg_wdata;
		case (reg_addr)
			A_CTRL_A: hp.alt = {8'h00, r.ctrl_a};
			A_CTRL_B: hp.alt = {8'h00, r.ctrl_b};
			A_DIV: hp.alt = {8'h00, r.div};
			A_MODE: hp.alt = {8'h00, r.mode};
			A_TIMER: hp.alt = r.timer;
			A_STATUS: hp.alt = {13'h0000, r.txq.valid, r.st != E_IDLE,
				cpb < MIN_BIT_CLKS};
			default: hp.alt = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.ctrl_a <= RST_CTRL_A;
			r.ctrl_b <= RST_CTRL_B;
			r.div <= RST_DIV;
			r.mode <= RST_MODE;
			r.rx_m <= 1'b1;
			r.rx_s <= 1'b1;
			r.rx_prev <= 1'b1;
			r.sampled <= 1'b1;
			r.can_tx <= 1'b1;
			r.st <= E_IDLE;
		end else begin
			r <= n;
		end
	end

	buf_mem #(
		.DEPTH(NBUF)
	) u_mem (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.h(hp),
		.h_rdata(reg_rdata),
		.e(ep),
		.e_rdata(erd)
	);

	assign can_tx = r.can_tx;
	assign sample_pulse = r.sample_pt;
	assign sampled_bit = r.sampled;
	assign overload_start = r.overload;
	assign store_req = r.store;
	assign tx_req = r.txq;
	assign freeze_counters = r.freeze;
	assign error_passive = r.freeze;

	// gap since the previous quantum tick, for the ratio check only
	logic [7:0] gap;
	logic clean;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gap <= 8'h00;
			clean <= 1'b0;
		// any prescaler restart by sync breaks the spacing being measured
		end else if (restart || (reg_wr && reg_addr == A_DIV)) begin
			gap <= 8'h00;
			clean <= 1'b0;
		end else if (tick) begin
			gap <= 8'h00;
			clean <= 1'b1;
		end else begin
			gap <= gap + 8'h01;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_listen_recessive: assert property (
		r.mode[MODE_LISTEN] |=> can_tx ##1 can_tx)
		else $error("transmit not recessive in listen-only");
	a_freeze_listen: assert property (
		r.mode[MODE_LISTEN] |=> freeze_counters && error_passive)
		else $error("counters not frozen in listen-only");
	a_remote_no_store: assert property (
		rx_frame.stb && rx_frame.rtr |=> !store_req.stb)
		else $error("remote frame sent to storage");
	a_prescale_ratio: assert property (
		tick && clean && !hard |-> gap == r.div)
		else $error("quantum tick spacing differs from divider");
	a_ts_capture: assert property (
		pos.id_start |=> r.cap == $past(r.timer))
		else $error("time stamp not captured at identifier");
	a_timer_sync: assert property (
		movein.stb && movein.idx == '0 && r.mode[MODE_TSYNC]
		|=> r.timer == 16'h0000)
		else $error("timer not reset on buffer 0 reception");
	a_remote_convert: assert property (
		r.st == E_TXD_WR && erd.code != CODE_RESPOND && erd.rtr
		|=> u_mem.r.ent[$past(r.p_txd.idx)].code == CODE_RX_EMPTY)
		else $error("sent remote buffer not turned to receive");
	a_tx_stamp: assert property (
		$rose(r.p_txd.stb) |-> ##[1:40] (ep.we && ep.wdata.ts == r.cap))
		else $error("transmit time stamp not written");
	a_auto_resp: assert property (
		r.st == E_SCAN_CMP && hit && !r.txq.valid |=> tx_req.valid &&
		tx_req.idx == $past(r.scan) && tx_req.remote == $past(erd.rtr))
		else $error("remote request not answered");
	a_ovl_inter: assert property (
		n.sample_pt && !r.rx_s && pos.intermission && pos.bit_idx < 4'h2
		|=> r.ovl_pend)
		else $error("intermission overload not armed");
	a_ovl_eof: assert property (
		n.sample_pt && !r.rx_s && pos.eof && pos.rx_role &&
		pos.bit_idx == 4'h6 |=> r.ovl_pend)
		else $error("end-of-frame overload not armed");
	a_ovl_delim: assert property (
		n.sample_pt && !r.rx_s && pos.delim && pos.bit_idx == 4'h7
		|=> r.ovl_pend)
		else $error("delimiter overload not armed");

	c_auto_resp: cover property ($rose(tx_req.valid));
	c_overload: cover property (overload_start);
	c_convert: cover property (r.st == E_TXD_WR && erd.rtr);
endmodule : can_remote_timestamp_bittiming

// File: tb/can_node_model.sv
module can_node_model (
	input wire logic sys_clk,
	input wire logic can_tx,
	output logic can_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drive_dom;
	initial drive_dom = 1'b0;
	// wired-and bus: dominant wins over a recessive node
	assign can_rx = can_tx & ~drive_dom;
	task automatic dominant(input int n);
		@(posedge sys_clk);
		drive_dom <= 1'b1;
		repeat (n) @(posedge sys_clk);
		drive_dom <= 1'b0;
	endtask : dominant
endmodule : can_node_model

// File: tb/can_remote_timestamp_bittiming_tb.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module can_remote_timestamp_bittiming_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import can_rtb_pkg::*;
	logic sys_clk, nrst, reg_wr, reg_rd, can_rx, can_tx, tx_bit, ack_req;
	logic [7:0] reg_addr;
	logic [DW-1:0] reg_wdata, reg_rdata, v, t;
	frame_pos_s pos;
	ev_s rx_frame, movein, tx_done, store_req;
	logic tx_grant, sample_pulse, sampled_bit, overload_start;
	tx_req_s tx_req;
	logic freeze_counters, error_passive, got;
	int n_mismatch, comparisons, n_store, n_ov, n_dom, n;
	localparam logic [28:0] ID0 = 29'h1234567;
	can_remote_timestamp_bittiming can_remote_timestamp_bittiming_i (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .can_rx(can_rx), .can_tx(can_tx), .pos(pos),
		.tx_bit(tx_bit), .ack_req(ack_req), .rx_frame(rx_frame),
		.movein(movein), .tx_done(tx_done), .tx_grant(tx_grant),
		.sample_pulse(sample_pulse), .sampled_bit(sampled_bit),
		.overload_start(overload_start), .store_req(store_req),
		.tx_req(tx_req), .freeze_counters(freeze_counters),
		.error_passive(error_passive));
	can_node_model can_node_model_i (.sys_clk(sys_clk), .can_tx(can_tx),
		.can_rx(can_rx));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		n_store <= n_store + int'(store_req.stb === 1'b1);
		n_ov <= n_ov + int'(overload_start === 1'b1);
		n_dom <= n_dom + int'(can_tx === 1'b0);
	end
	function automatic logic [7:0] ba(input int i, input logic [1:0] w);
		return 8'h80 | 8'(i * 4) | 8'(w);
	endfunction : ba
	task automatic wr(input logic [7:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic setbuf(input int i, input logic [DW-1:0] c,
		input logic [28:0] id);
		wr(ba(i, W_IDH), {3'h0, id[28:16]});
		wr(ba(i, W_IDL), id[15:0]);
		wr(ba(i, W_CTRL), c);
	endtask : setbuf
	task automatic ev(input int k, input logic r, input int i,
		input logic [28:0] id);
		ev_s e;
		e = '{1'b1, r, 1'b1, 4'(i), id};
		@(posedge sys_clk);
		case (k)
			0: rx_frame <= e;
			1: movein <= e;
			default: tx_done <= e;
		endcase
		@(posedge sys_clk);
		rx_frame <= '0;
		movein <= '0;
		tx_done <= '0;
	endtask : ev
	// bounded wait for the response request, then let arbitration take it
	task automatic wait_req();
		got = 1'b0;
		repeat (60) begin
			@(posedge sys_clk);
			if (tx_req.valid === 1'b1) got = 1'b1;
		end
		tx_grant <= 1'b1;
		@(posedge sys_clk);
		tx_grant <= 1'b0;
	endtask : wait_req
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		#(20000 * 5);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{reg_wr, reg_rd, tx_grant, ack_req, nrst} = '0;
		{reg_addr, reg_wdata, pos, rx_frame, movein, tx_done} = '0;
		tx_bit = 1'b1;
		{n_mismatch, comparisons, n_store, n_ov, n_dom} = '0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(A_CTRL_A, v); `CHK(v, 16'h0003)
		rd(A_CTRL_B, v); `CHK(v, 16'h005B)
		rd(A_DIV, v); `CHK(v, 16'h0004)
		rd(A_MODE, v); `CHK(v, 16'h0000)
		rd(8'h40, v); `CHK(v, 16'h0000)
		wr(A_DIV, 16'h00FF);
		rd(A_DIV, v); `CHK(v, 16'h00FF)
		setbuf(3, 16'h002A, ID0);
		setbuf(2, 16'h002A, ID0 ^ 29'h1);
		ev(0, 1'b1, 0, ID0);
		wait_req();
		`CHK({got, tx_req.idx, tx_req.remote}, 6'h26)
		ev(0, 1'b1, 0, ID0 ^ 29'h100);
		wait_req();
		`CHK(got, 1'b0)
		setbuf(3, 16'h003A, ID0);
		ev(0, 1'b1, 0, ID0);
		wait_req();
		`CHK({got, tx_req.idx, tx_req.remote}, 6'h27)
		`CHK(n_store, 0)
		ev(0, 1'b0, 0, ID0);
		repeat (3) @(posedge sys_clk);
		`CHK(n_store, 1)
		setbuf(4, 16'h0038, ID0);
		// timer read and capture share one edge, so both see one count
		@(posedge sys_clk);
		pos.id_start <= 1'b1;
		reg_rd <= 1'b1;
		reg_addr <= A_TIMER;
		@(posedge sys_clk);
		pos.id_start <= 1'b0;
		reg_rd <= 1'b0;
		#1 t = reg_rdata;
		rd(ba(4, 2'h3), v); `CHK(v, 16'h0000)
		ev(2, 1'b1, 4, ID0);
		repeat (6) @(posedge sys_clk);
		rd(ba(4, W_CTRL), v); `CHK(v[3:0], CODE_RX_EMPTY)
		rd(ba(4, W_IDL), v); `CHK(v, ID0[15:0])
		rd(ba(4, 2'h3), v); `CHK(v, t)
		ev(1, 1'b0, 5, ID0 ^ 29'h5);
		repeat (4) @(posedge sys_clk);
		rd(ba(5, W_CTRL), v); `CHK(v[3:0], CODE_RX_FULL)
		rd(ba(5, 2'h3), v); `CHK(v, t)
		wr(A_MODE, 16'h0002);
		ev(1, 1'b0, 0, ID0);
		rd(A_TIMER, v); `CHK(v, 16'h0000)
		wr(A_DIV, 16'h0001);
		n = 0;
		// old prescaler count may have to wrap before the first tick
		repeat (400) begin
			@(posedge sys_clk);
			if (sample_pulse === 1'b1) break;
		end
		repeat (200) begin
			@(posedge sys_clk);
			n++;
			if (sample_pulse === 1'b1) break;
		end
		`CHK(n, 2 * (1 + 4 + 4 + 4))
		`CHK(sampled_bit, 1'b1)
		pos.busy <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			pos.intermission <= (k < 2);
			pos.eof <= (k == 2);
			pos.rx_role <= (k == 2);
			pos.delim <= (k == 3);
			pos.bit_idx <= (k == 0) ? 4'h0 : (k == 1) ? 4'h2 :
				(k == 2) ? 4'h6 : 4'h7;
			n = n_ov;
			can_node_model_i.dominant(32);
			repeat (40) @(posedge sys_clk);
			`CHK(n_ov != n, k != 1)
		end
		pos <= '0;
		ack_req <= 1'b1;
		n = n_dom;
		repeat (80) @(posedge sys_clk);
		`CHK(n_dom != n, 1'b1)
		`CHK(sampled_bit, 1'b0)
		wr(A_MODE, 16'h0001);
		// last pre-listen transmit value is still sampled one edge later
		repeat (2) @(posedge sys_clk);
		n = n_dom;
		tx_bit <= 1'b0;
		repeat (100) @(posedge sys_clk);
		`CHK(n_dom, n)
		`CHK({freeze_counters, error_passive}, 2'h3)
		give_verdict();
	end
endmodule : can_remote_timestamp_bittiming_tb
